//--- hw/pfc_bank.sv
// pfc_bank: pin configuration bank with function routing and pad control.
// assumes a classic wishbone master on clk_i, pads whose inputs are asynchronous,
// and peripherals on clk_i.
`timescale 1ns/100ps
`include "pfc_defines.svh"

module pfc_bank
  import pfc_pkg::*;
(
  input  wire logic               clk_i,               // system clock, 100 MHz
  input  wire logic               rst_i,               // synchronous reset, active high
  // wishbone slave
  input  wire logic               wb_cyc_i,            // bus cycle
  input  wire logic               wb_stb_i,            // strobe
  input  wire logic               wb_we_i,             // write enable
  input  wire pfc_pkg::pfc_adr_t  wb_adr_i,            // byte address
  input  wire pfc_pkg::pfc_sel_t  wb_sel_i,            // byte lanes
  input  wire pfc_pkg::pfc_word_t wb_dat_i,            // write data
  output logic                    wb_ack_o,            // acknowledge
  output pfc_pkg::pfc_word_t      wb_dat_o,            // read data
  // pads
  input  wire pfc_pkg::pfc_pins_t pad_in_i,            // pad levels, asynchronous
  output pfc_pkg::pfc_pins_t      pad_out_o,           // pad output level
  output pfc_pkg::pfc_pins_t      pad_oe_o,            // pad drive enable
  output pfc_pkg::pfc_pins_t      pad_pull_up_o,       // pull-up resistor on
  output pfc_pkg::pfc_pins_t      pad_pull_down_o,     // pull-down resistor on
  output pfc_pkg::pfc_pins_t      hysteresis_enable_o, // input hysteresis on
  output pfc_pkg::pfc_pins_t      slew_fast_o,         // fast output driver
  output pfc_pkg::pfc_pins_t      analog_mode_o,       // analog mode, receiver cut
  output pfc_pkg::pfc_pins_t      glitch_filter_bypass_o, // filter bypassed
  // general-purpose port
  input  wire pfc_pkg::pfc_pins_t gpio_out_i,          // port output data
  input  wire pfc_pkg::pfc_pins_t gpio_dir_i,          // port direction, 1 output
  output pfc_pkg::pfc_pins_t      gpio_in_o,           // port input after polarity
  // peripheral outputs toward pads
  input  wire logic               uart_txd_i,          // uart transmit
  input  wire logic               uart_rts_i,          // uart request to send
  input  wire logic               usart_sync_clock_i,  // usart synchronous clock
  input  wire logic               timer32_match0_i,    // 32-bit timer match 0
  input  wire logic               clock_out_signal_i,  // clock output
  input  wire logic               spi_data_out_i,      // spi data out
  input  wire logic               spi_select_i,        // spi select
  input  wire logic               spi_clock_i,         // spi clock
  input  wire logic               scl_pull_low_i,      // two-wire clock drive low
  // pad inputs toward peripherals
  output logic                    uart_rxd_o,          // uart receive, idle high
  output logic                    scl_in_o,            // two-wire clock level, idle high
  output logic                    external_clock_in_o, // external clock input
  output logic                    timer32_capture0_o,  // 32-bit timer capture 0
  output logic                    timer32_capture2_o,  // 32-bit timer capture 2
  output logic                    timer16_capture0_o   // 16-bit timer capture 0
);
  import pfc_pkg::*;

  // slots run in offset order, pin9 first; pins 14 and 17 have no register here
  // layout i pins live outside this bank, so only layouts d and a occur
  // layout of each bank slot, in offset order
  function automatic pfc_layout_e pfc_layout(input logic [3:0] ix);
    logic [`PFC_NPINS-1:0] is_d;
    is_d = 16'hf788;
    pfc_layout = is_d[ix] ? PFC_LAYOUT_D : PFC_LAYOUT_A;
  endfunction

  // reset image per layout; reserved bits 8:7 of layout d read back as 01
  // no reset pin in this bank, so hysteresis resets off on every slot
  function automatic pfc_cfg_t pfc_reset(input logic [3:0] ix);
    pfc_reset = (pfc_layout(ix) == PFC_LAYOUT_D) ? `PFC_RST_D : `PFC_RST_A;
  endfunction

  // writable bits per layout; anything outside the mask snaps back to reset
  function automatic pfc_cfg_t pfc_wmask(input logic [3:0] ix);
    pfc_wmask = (pfc_layout(ix) == PFC_LAYOUT_D) ? `PFC_WMASK_D : `PFC_WMASK_A;
  endfunction

  // address decode: bit 4 is hit, bits 3:0 slot
  // unmapped offsets, the holes at 0x038 and 0x044 among them, give no hit:
  // writes there are dropped and reads return zero, but they are still acked
  // so a stray access never stalls the bus
  function automatic logic [4:0] pfc_decode(input pfc_adr_t a);
    case (a)
      `PFC_OFF_PIN9:  pfc_decode = 5'h10;
      `PFC_OFF_PIN10: pfc_decode = 5'h11;
      `PFC_OFF_PIN11: pfc_decode = 5'h12;
      `PFC_OFF_PIN12: pfc_decode = 5'h13;
      `PFC_OFF_PIN13: pfc_decode = 5'h14;
      `PFC_OFF_PIN15: pfc_decode = 5'h15;
      `PFC_OFF_PIN16: pfc_decode = 5'h16;
      `PFC_OFF_PIN18: pfc_decode = 5'h17;
      `PFC_OFF_PIN19: pfc_decode = 5'h18;
      `PFC_OFF_PIN20: pfc_decode = 5'h19;
      `PFC_OFF_PIN21: pfc_decode = 5'h1a;
      `PFC_OFF_PIN22: pfc_decode = 5'h1b;
      `PFC_OFF_PIN23: pfc_decode = 5'h1c;
      `PFC_OFF_PIN24: pfc_decode = 5'h1d;
      `PFC_OFF_PIN25: pfc_decode = 5'h1e;
      `PFC_OFF_PIN26: pfc_decode = 5'h1f;
      default:        pfc_decode = 5'h00;
    endcase
  endfunction

  // configuration store, one 11-bit word per slot; bits 31:11 are not kept
  // since they always read zero
  pfc_cfg_t   cfg_r [`PFC_NPINS];
  logic       ack_r;
  pfc_word_t  dat_r;
  // pad input synchroniser
  pfc_pins_t  sync1_r;
  pfc_pins_t  sync2_r;
  // registered pad controls and their next values
  pfc_pins_t  pad_out_r;
  pfc_pins_t  pad_out_nxt;
  pfc_pins_t  pad_oe_r;
  pfc_pins_t  pad_oe_nxt;
  pfc_pins_t  pull_up_r;
  pfc_pins_t  pull_up_nxt;
  pfc_pins_t  pull_dn_r;
  pfc_pins_t  pull_dn_nxt;
  // received levels toward the port and the peripherals
  pfc_pins_t  gpio_in_r;
  pfc_pins_t  rx_nxt;
  logic [5:0] periph_r;
  logic [5:0] periph_nxt;

  // bus decode and write merge
  // access is masked while ack stands, so a request held past its ack is
  // taken again only every second cycle
  // lanes 2 and 3 carry no configuration bits and are ignored
  wire logic [4:0] dec       = pfc_decode(wb_adr_i);
  wire logic       hit       = dec[4];
  wire logic [3:0] slot      = dec[3:0];
  wire logic       access    = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic       wr_en     = access & wb_we_i & hit;
  wire pfc_cfg_t   lane_mask = {{3{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire pfc_cfg_t   wr_merge  = (cfg_r[slot] & ~lane_mask) | (wb_dat_i[`PFC_CFG_W-1:0] & lane_mask);
  wire pfc_cfg_t   wr_value  = (wr_merge & pfc_wmask(slot)) | (pfc_reset(slot) & ~pfc_wmask(slot));
  wire pfc_word_t  rd_value  = hit ? {21'h0, cfg_r[slot]} : 32'h00000000;

  // configuration registers; reserved bits can never leave reset value
  // a write lands on the edge that takes the request, the same edge that raises ack
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `PFC_NPINS; i++) begin
      if (rst_i) begin
        cfg_r[i] <= pfc_reset(4'(i));
      end else if (wr_en && slot == 4'(i)) begin
        cfg_r[i] <= wr_value;
      end
    end
  end

  // one wait state; ack drops the cycle after it is given
  // read data is zero outside ack, so several slaves may be ored together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= access;
      dat_r <= access ? rd_value : 32'h00000000;
    end
  end

  // two-flop synchroniser on pads, nothing reads the first stage
  // pads are asynchronous; without it a metastable level could reach the
  // function mux, the polarity logic and the repeater pulls at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
    end else begin
      sync1_r <= pad_in_i;
      sync2_r <= sync1_r;
    end
  end

  // received level per pin: polarity applied, zero while analog
  // forcing zero in analog mode keeps a mid-rail pad from toggling logic
  always_comb begin
    for (int i = 0; i < `PFC_NPINS; i++) begin
      rx_nxt[i] = (sync2_r[i] ^ cfg_r[i][`PFC_INV_BIT])
                  & ((pfc_layout(4'(i)) != PFC_LAYOUT_A) | cfg_r[i][`PFC_ADM_BIT]);
    end
  end

  // pad drive and pulls; open drain only lets the pad be driven low
  // trade-off: every route costs one cycle through the output flops, but no
  // pad can glitch while a configuration word is being rewritten
  always_comb begin
    logic [2:0] fs;
    logic       d;
    logic       en;
    fs = 3'h0;
    d  = 1'b0;
    en = 1'b0;
    pad_out_nxt = 16'h0000;
    pad_oe_nxt  = 16'h0000;
    pull_up_nxt = 16'h0000;
    pull_dn_nxt = 16'h0000;
    for (int i = 0; i < `PFC_NPINS; i++) begin
      fs = cfg_r[i][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
      d  = 1'b0;
      en = 1'b0;
      // no reset pin lives in this bank, so 000 is the port everywhere
      if (fs == `PFC_FN_PORT) begin
        d  = gpio_out_i[i];
        en = gpio_dir_i[i];
      end else begin
        case (4'(i))
          `PFC_IX_PIN12: begin
            if (fs == `PFC_FN_ALT3) begin
              d  = timer32_match0_i;
              en = 1'b1;
            end else if (fs == `PFC_FN_ALT4) begin
              // two-wire clock: the pad only ever pulls low
              en = scl_pull_low_i;
            end
          end
          `PFC_IX_PIN19: begin
            if (fs == `PFC_FN_ALT2) begin
              d  = clock_out_signal_i;
              en = 1'b1;
            end else if (fs == `PFC_FN_ALT3) begin
              d  = spi_data_out_i;
              en = 1'b1;
            end
          end
          `PFC_IX_PIN23: begin
            if (fs == `PFC_FN_ALT1) begin
              d  = uart_rts_i;
              en = 1'b1;
            end else if (fs == `PFC_FN_ALT4) begin
              d  = usart_sync_clock_i;
              en = 1'b1;
            end
          end
          `PFC_IX_PIN18: begin
            d  = spi_select_i;
            en = (fs == `PFC_FN_ALT2);
          end
          `PFC_IX_PIN20: begin
            d  = spi_clock_i;
            en = (fs == `PFC_FN_ALT2);
          end
          `PFC_IX_PIN26: begin
            d  = uart_txd_i;
            en = (fs == `PFC_FN_ALT1);
          end
          `PFC_IX_PIN24: begin
            en = (fs == `PFC_FN_ALT1) & scl_pull_low_i;
          end
          default: begin
            en = 1'b0;                                    // reserved or input-only codes
          end
        endcase
      end
      pad_out_nxt[i] = d;
      pad_oe_nxt[i]  = en & (~cfg_r[i][`PFC_OD_BIT] | ~d);
      case (cfg_r[i][`PFC_PULL_HI:`PFC_PULL_LO])
        `PFC_PULL_UP:     pull_up_nxt[i] = 1'b1;
        `PFC_PULL_DOWN:   pull_dn_nxt[i] = 1'b1;
        `PFC_PULL_REPEAT: begin
          pull_up_nxt[i] = sync2_r[i];
          pull_dn_nxt[i] = ~sync2_r[i];
        end
        default: begin
          pull_up_nxt[i] = 1'b0;
          pull_dn_nxt[i] = 1'b0;
        end
      endcase
    end
  end

  // peripheral inputs; unselected ones rest at their idle level
  // uart receive and two-wire clock idle high, clock input and captures low
  wire logic [2:0] fs12 = cfg_r[`PFC_IX_PIN12][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
  wire logic [2:0] fs18 = cfg_r[`PFC_IX_PIN18][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
  wire logic [2:0] fs19 = cfg_r[`PFC_IX_PIN19][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
  wire logic [2:0] fs23 = cfg_r[`PFC_IX_PIN23][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
  wire logic [2:0] fs24 = cfg_r[`PFC_IX_PIN24][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
  wire logic [2:0] fs26 = cfg_r[`PFC_IX_PIN26][`PFC_FUNCTION_SELECT_HI:`PFC_FUNCTION_SELECT_LO];
  // several pins may feed the same input; lower pin number wins
  // software is expected to route each input from one pin only
  always_comb begin
    periph_nxt[0] = (fs12 == `PFC_FN_ALT1) ? rx_nxt[`PFC_IX_PIN12] : 1'b1;
    if (fs12 == `PFC_FN_ALT4) begin
      periph_nxt[1] = rx_nxt[`PFC_IX_PIN12];
    end else if (fs24 == `PFC_FN_ALT1) begin
      periph_nxt[1] = rx_nxt[`PFC_IX_PIN24];
    end else begin
      periph_nxt[1] = 1'b1;
    end
    if (fs12 == `PFC_FN_ALT5) begin
      periph_nxt[2] = rx_nxt[`PFC_IX_PIN12];
    end else if (fs19 == `PFC_FN_ALT1) begin
      periph_nxt[2] = rx_nxt[`PFC_IX_PIN19];
    end else if (fs24 == `PFC_FN_ALT2) begin
      periph_nxt[2] = rx_nxt[`PFC_IX_PIN24];
    end else begin
      periph_nxt[2] = 1'b0;
    end
    periph_nxt[3] = (fs23 == `PFC_FN_ALT3) & rx_nxt[`PFC_IX_PIN23];
    periph_nxt[4] = (fs26 == `PFC_FN_ALT4) & rx_nxt[`PFC_IX_PIN26];
    periph_nxt[5] = (fs18 == `PFC_FN_ALT3) & rx_nxt[`PFC_IX_PIN18];
  end

  // every output leaves through a flop
  // periph_r resets to the idle levels, uart receive and two-wire clock high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_out_r <= 16'h0000;
      pad_oe_r  <= 16'h0000;
      pull_up_r <= 16'h0000;
      pull_dn_r <= 16'h0000;
      gpio_in_r <= 16'h0000;
      periph_r  <= 6'h03;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r  <= pad_oe_nxt;
      pull_up_r <= pull_up_nxt;
      pull_dn_r <= pull_dn_nxt;
      gpio_in_r <= rx_nxt;
      periph_r  <= periph_nxt;
    end
  end

  // static pad controls taken straight from the configuration flops
  // no extra register here, so a pad setting follows the edge that writes it;
  // layout d slots have no analog mode and never filter
  always_comb begin
    for (int i = 0; i < `PFC_NPINS; i++) begin
      hysteresis_enable_o[i]    = cfg_r[i][`PFC_HYS_BIT];
      slew_fast_o[i]            = cfg_r[i][`PFC_SLEW_BIT];
      analog_mode_o[i]          = (pfc_layout(4'(i)) == PFC_LAYOUT_A) & ~cfg_r[i][`PFC_ADM_BIT];
      glitch_filter_bypass_o[i] = (pfc_layout(4'(i)) != PFC_LAYOUT_A) | cfg_r[i][`PFC_FILT_BIT];
    end
  end

  // port drivers
  assign wb_ack_o            = ack_r;
  assign wb_dat_o            = dat_r;
  assign pad_out_o           = pad_out_r;
  assign pad_oe_o            = pad_oe_r;
  assign pad_pull_up_o       = pull_up_r;
  assign pad_pull_down_o     = pull_dn_r;
  assign gpio_in_o           = gpio_in_r;
  assign uart_rxd_o          = periph_r[0];
  assign scl_in_o            = periph_r[1];
  assign external_clock_in_o = periph_r[2];
  assign timer32_capture0_o  = periph_r[3];
  assign timer32_capture2_o  = periph_r[4];
  assign timer16_capture0_o  = periph_r[5];

endmodule

//--- hw/pfc_defines.svh
// pfc_defines.svh: offsets, field positions, reset values and codes of the pin configuration bank.
// assumes byte addresses on the register bus, word aligned.
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

`define PFC_NPINS        16
`define PFC_ADR_W        8
`define PFC_CFG_W        11

// register byte offsets
`define PFC_OFF_PIN9     8'h24
`define PFC_OFF_PIN10    8'h28
`define PFC_OFF_PIN11    8'h2c
`define PFC_OFF_PIN12    8'h30
`define PFC_OFF_PIN13    8'h34
`define PFC_OFF_PIN15    8'h3c
`define PFC_OFF_PIN16    8'h40
`define PFC_OFF_PIN18    8'h48
`define PFC_OFF_PIN19    8'h4c
`define PFC_OFF_PIN20    8'h50
`define PFC_OFF_PIN21    8'h54
`define PFC_OFF_PIN22    8'h58
`define PFC_OFF_PIN23    8'h5c
`define PFC_OFF_PIN24    8'h60
`define PFC_OFF_PIN25    8'h64
`define PFC_OFF_PIN26    8'h68

// bank slot of each routed pin
`define PFC_IX_PIN12     4'h3
`define PFC_IX_PIN18     4'h7
`define PFC_IX_PIN19     4'h8
`define PFC_IX_PIN20     4'h9
`define PFC_IX_PIN23     4'hc
`define PFC_IX_PIN24     4'hd
`define PFC_IX_PIN26     4'hf

// field positions
`define PFC_FUNCTION_SELECT_HI      2
`define PFC_FUNCTION_SELECT_LO      0
`define PFC_PULL_HI      4
`define PFC_PULL_LO      3
`define PFC_HYS_BIT      5
`define PFC_INV_BIT      6
`define PFC_ADM_BIT      7
`define PFC_FILT_BIT     8
`define PFC_SLEW_BIT     9
`define PFC_OD_BIT       10

// reset values and writable masks per layout
`define PFC_RST_D        11'h090
`define PFC_RST_A        11'h190
`define PFC_WMASK_D      11'h67f
`define PFC_WMASK_A      11'h7ff

// pull field codes
`define PFC_PULL_DOWN    2'h1
`define PFC_PULL_UP      2'h2
`define PFC_PULL_REPEAT  2'h3

// function_select codes
`define PFC_FN_PORT      3'h0
`define PFC_FN_ALT1      3'h1
`define PFC_FN_ALT2      3'h2
`define PFC_FN_ALT3      3'h3
`define PFC_FN_ALT4      3'h4
`define PFC_FN_ALT5      3'h5

`endif

//--- hw/pfc_pkg.sv
// pfc_pkg: types shared by the pin configuration bank.
// assumes pfc_defines.svh for all numeric constants.
`include "pfc_defines.svh"

package pfc_pkg;
  typedef logic [31:0]               pfc_word_t;
  typedef logic [`PFC_ADR_W-1:0]     pfc_adr_t;
  typedef logic [`PFC_NPINS-1:0]     pfc_pins_t;
  typedef logic [`PFC_CFG_W-1:0]     pfc_cfg_t;
  typedef logic [3:0]                pfc_sel_t;
  typedef enum {PFC_LAYOUT_D, PFC_LAYOUT_I, PFC_LAYOUT_A} pfc_layout_e;
endpackage

//--- testbench/pfc_bank_properties.sv
// pfc_bank_properties: port-level checks on the pin configuration bank.
// assumes one clock domain and a synchronous active-high reset; bound below.
`timescale 1ns/100ps
module pfc_bank_properties
  import pfc_pkg::*;
(
  input wire logic               clk_i,                 // clock
  input wire logic               rst_i,                 // reset
  input wire logic               wb_cyc_i,              // bus cycle
  input wire logic               wb_stb_i,              // strobe
  input wire logic               wb_we_i,               // write enable
  input wire pfc_pkg::pfc_adr_t  wb_adr_i,              // byte address
  input wire pfc_pkg::pfc_word_t wb_dat_i,              // write data
  input wire logic               wb_ack_o,              // acknowledge
  input wire pfc_pkg::pfc_word_t wb_dat_o,              // read data
  input wire pfc_pkg::pfc_pins_t pad_oe_o,              // drive enable
  input wire pfc_pkg::pfc_pins_t pad_pull_up_o,         // pull-up on
  input wire pfc_pkg::pfc_pins_t pad_pull_down_o,       // pull-down on
  input wire pfc_pkg::pfc_pins_t hysteresis_enable_o,   // hysteresis
  input wire pfc_pkg::pfc_pins_t slew_fast_o,           // fast driver
  input wire pfc_pkg::pfc_pins_t analog_mode_o,         // analog mode
  input wire pfc_pkg::pfc_pins_t glitch_filter_bypass_o // filter bypass
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus handshake: one ack, exactly one cycle after the request is taken
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_DAT_RSVD: assert property (wb_ack_o |-> wb_dat_o[31:11] == 21'h0)
    else $error("reserved read bits set");
  // slew of pin12 only rises through a write of bit 9 to its register
  AST_SLEW_WRITE: assert property ($rose(slew_fast_o[3]) |-> wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h30 && wb_dat_i[9]))
    else $error("slew rose without write");
  // layout d slots have no analog mode and no glitch filter
  AST_D_FIXED: assert property ((analog_mode_o & 16'hf788) == 16'h0 && (glitch_filter_bypass_o & 16'hf788) == 16'hf788)
    else $error("layout d slot shows analog or filter");
  // repeater picks one resistor, never both
  AST_PULL_EXCL: assert property ((pad_pull_up_o & pad_pull_down_o) == 16'h0)
    else $error("both pulls on");
  AST_RST_CFG: assert property ($fell(rst_i) |-> slew_fast_o == 16'h0 && hysteresis_enable_o == 16'h0 && analog_mode_o == 16'h0 && glitch_filter_bypass_o == 16'hffff)
    else $error("pad config not at reset value");
  AST_RST_PULL: assert property ($fell(rst_i) |-> ##2 pad_pull_up_o == 16'hffff && pad_pull_down_o == 16'h0)
    else $error("pulls not at reset value");

  // main scenarios reached
  CVR_WRITE: cover property (wb_ack_o && wb_we_i);
  CVR_REPEAT_DOWN: cover property (pad_pull_down_o[3] && $past(pad_pull_up_o[3]));
  CVR_TXD_DRIVE: cover property (pad_oe_o[15]);
endmodule

bind pfc_bank pfc_bank_properties u_props (.*);

//--- testbench/tb_pin_function_config_bank.sv
// tb_pin_function_config_bank: self-checking bench for the pin configuration bank.
// assumes pfc_bank with classic wishbone; the bench plays bus master, pads and peripherals.
`timescale 1ns/100ps
module tb_pin_function_config_bank;
  import pfc_pkg::*;
  logic      clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  pfc_adr_t  wb_adr_i;
  pfc_sel_t  wb_sel_i;
  pfc_word_t wb_dat_i, wb_dat_o;
  pfc_pins_t pad_in_i, pad_out_o, pad_oe_o, pad_pull_up_o, pad_pull_down_o, gpio_in_o;
  pfc_pins_t hysteresis_enable_o, slew_fast_o, analog_mode_o, glitch_filter_bypass_o, gpio_out_i, gpio_dir_i;
  logic      uart_txd_i, uart_rts_i, usart_sync_clock_i, timer32_match0_i, clock_out_signal_i;
  logic      spi_data_out_i, spi_select_i, spi_clock_i, scl_pull_low_i;
  logic      uart_rxd_o, scl_in_o, external_clock_in_o, timer32_capture0_o, timer32_capture2_o, timer16_capture0_o;
  logic [8:0] per_r;
  logic [5:0] pin_in;
  int        miscompares = 0;
  int        n_tests = 0;
  // slot order of the bank; bit set where the slot is layout d
  pfc_adr_t  offs [16] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h40, 8'h48,
                          8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h64, 8'h68};
  localparam logic [15:0] DMASK = 16'hf788;
  // route table: slot, code, kind (0 out, 1 in, 2 scl), peripheral index; assigned codes only
  logic [15:0] rt [18] = '{16'h3110, 16'h3303, 16'h3428, 16'h3512, 16'h8112, 16'h8204,
                           16'h8305, 16'hc101, 16'hc313, 16'hc402, 16'h7206, 16'h7315,
                           16'h9207, 16'hf100, 16'hf414, 16'hd128, 16'hd212, 16'h3000};

  // peripherals gathered into vectors so the route table can index them
  assign {scl_pull_low_i, spi_clock_i, spi_select_i, spi_data_out_i, clock_out_signal_i,
          timer32_match0_i, usart_sync_clock_i, uart_rts_i, uart_txd_i} = per_r;
  assign pin_in = {timer16_capture0_o, timer32_capture2_o, timer32_capture0_o,
                   external_clock_in_o, scl_in_o, uart_rxd_o};

  pfc_bank dut (.*);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // single classic cycle; ack is read at the edge, before that edge's updates land
  task automatic wb(input logic we, input pfc_adr_t a, input pfc_word_t d, input pfc_sel_t s,
                    output pfc_word_t q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      $display("BAD %0t bus timeout", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input pfc_adr_t a, input pfc_word_t d, input pfc_sel_t s = 4'hf);
    pfc_word_t q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic rdchk(input pfc_adr_t a, input pfc_word_t e, input string w);
    pfc_word_t q;
    wb(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e, w);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // pin9 is written with function code 001 here, though 000 selects its port like every slot
  task automatic t_regs;
    logic        d;
    logic [31:0] f;
    for (int i = 0; i < 16; i++) begin
      d = DMASK[i];
      f = {31'h0, i == 0};
      rdchk(offs[i], d ? 32'h90 : 32'h190, "reset value");
      wr(offs[i], 32'hffff_fff8 | f);
      rdchk(offs[i], (d ? 32'h6f8 : 32'h7f8) | f, "all ones");
      wr(offs[i], f);
      rdchk(offs[i], (d ? 32'h80 : 32'h0) | f, "all zeros");
      wr(offs[i], (d ? 32'h90 : 32'h190) | f);
    end
  endtask

  task automatic t_unmapped;
    wr(8'h38, 32'hffff_ffff);
    rdchk(8'h38, 32'h0, "hole 38");
    rdchk(8'h44, 32'h0, "hole 44");
    rdchk(8'h6c, 32'h0, "past end");
    wr(8'h30, 32'h7ff, 4'h2);
    rdchk(8'h30, 32'h690, "lane 1");
    wr(8'h30, 32'h0, 4'h1);
    rdchk(8'h30, 32'h680, "lane 0");
    wr(8'h30, 32'h90);
  endtask

  // pin12 as port: drive, open drain, slew, hysteresis, inversion
  task automatic t_pad;
    @(posedge clk_i);
    gpio_dir_i[3] <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_i);
      gpio_out_i[3] <= v[0];
      tick(3);
      chk(pad_out_o[3], v, "port out");
      chk(pad_oe_o[3], 32'h1, "port oe");
    end
    wr(8'h30, 32'h490);
    tick(2);
    chk(pad_oe_o[3], 32'h0, "open drain high");
    @(posedge clk_i);
    gpio_out_i[3] <= 1'b0;
    tick(3);
    chk(pad_oe_o[3], 32'h1, "open drain low oe");
    chk(pad_out_o[3], 32'h0, "open drain low");
    wr(8'h30, 32'h2b0);
    tick(2);
    chk(slew_fast_o[3], 32'h1, "slew");
    chk(hysteresis_enable_o[3], 32'h1, "hysteresis");
    @(posedge clk_i);
    gpio_dir_i[3] <= 1'b0;
    pad_in_i[3] <= 1'b1;
    tick(4);
    chk(gpio_in_o[3], 32'h1, "plain input");
    wr(8'h30, 32'h0d0);
    tick(4);
    chk(gpio_in_o[3], 32'h0, "inverted input");
    wr(8'h30, 32'h90);
  endtask

  // every pull code with the pad at both levels; repeater follows the pad
  task automatic t_pulls;
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 2; b++) begin
        @(posedge clk_i);
        pad_in_i[3] <= b[0];
        wr(8'h30, 32'h80 | (p << 3));
        tick(4);
        chk(pad_pull_up_o[3], (p == 2) || (p == 3 && b == 1), "pull up");
        chk(pad_pull_down_o[3], (p == 1) || (p == 3 && b == 0), "pull down");
      end
    end
    wr(8'h30, 32'h90);
  endtask

  task automatic t_routes;
    logic [3:0] s, k, x;
    for (int e = 0; e < 17; e++) begin
      s = rt[e][15:12];
      k = rt[e][7:4];
      x = rt[e][3:0];
      wr(offs[s], 32'h90 | rt[e][11:8]);
      for (int v = 0; v < 2; v++) begin
        @(posedge clk_i);
        per_r[x] <= v[0];
        pad_in_i[s] <= v[0];
        tick(4);
        if (k == 4'h0) begin
          chk(pad_out_o[s], v, "route out");
          chk(pad_oe_o[s], 32'h1, "route oe");
        end else if (k == 4'h1) begin
          chk(pin_in[x], v, "route in");
        end else begin
          chk({pad_out_o[s], pad_oe_o[s], scl_in_o}, {1'b0, v[0], v[0]}, "route scl");
        end
      end
      wr(offs[s], 32'h90);
    end
  endtask

  // pin11 is layout a: analog mode cuts the receiver, filter bit shows
  task automatic t_analog;
    @(posedge clk_i);
    pad_in_i[2] <= 1'b1;
    wr(8'h2c, 32'h10);
    tick(4);
    chk({analog_mode_o[2], glitch_filter_bypass_o[2], gpio_in_o[2]}, 32'h4, "analog");
    wr(8'h2c, 32'h190);
    tick(4);
    chk({analog_mode_o[2], glitch_filter_bypass_o[2], gpio_in_o[2]}, 32'h3, "digital");
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    pad_in_i = 16'h0;
    gpio_out_i = 16'h0;
    gpio_dir_i = 16'h0;
    per_r = 9'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_unmapped();
    t_pad();
    t_pulls();
    t_routes();
    t_analog();
    tally_and_finish();
  end
endmodule
